// ===== core/edge_pulse_shift_register4.sv
// Four-stage edge-strobed shift register with running-light mode
`timescale 1ns/10ps
`default_nettype none
module edge_pulse_shift_register4
    import edge_shift_pkg::*;
#(
    parameter int SCAN_COUNT = SCAN_CYCLES,
    parameter int FLASH_COUNT = FLASH_CYCLES,
    parameter int DATA_WIDTH = STAGE_COUNT,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Switch inputs from pins
    input wire logic shift_pulse_in,
    input wire logic value_in,
    input wire logic clear_in,
    // Static configuration from a pin
    input wire logic ringMode,
    // Storage stage outputs
    output logic stage_first,
    output logic stage_second,
    output logic stage_third,
    output logic stage_fourth,
    // Lamp relays for ring mode
    output logic lamp_out_first,
    output logic lamp_out_last,
    // Internal status
    output logic shift_strobe,
    output logic releasePulse,
    output logic pulse_lockout_flag,
    output logic ring_seeded_flag,
    output logic flasher_timer,
    output logic scanTick,
    // Stage snapshot stream
    output logic snapValid,
    input wire logic snapReady,
    output logic [DATA_WIDTH-1:0] snapData
);

    localparam int SCAN_W = $clog2(SCAN_COUNT + 1);
    localparam int FLASH_W = $clog2(FLASH_COUNT + 1);

    // Synchroniser flops, first then second
    logic [3:0] syncA_ff;
    logic [3:0] syncB_ff;
    logic pulseSync;
    logic valueSync;
    logic clearSync;
    logic modeSync;

    // Scan timing and flasher
    logic [SCAN_W-1:0] scanCnt_ff;
    logic scanTick_ff;
    logic [FLASH_W-1:0] flashCnt_ff;
    logic flash_ff;

    // Mode latched per scan
    logic mode_ff;

    // Shift path
    logic shiftSrc;
    logic strobe;
    logic fallEdge;
    logic lockout;
    logic [3:0] stage_ff;
    logic [3:0] nxt_stage;
    logic seeded_ff;
    logic shiftIn;
    logic doShift;
    logic fifoReady;
    shift_state_e state_ff;
    shift_state_e nxt_state;

    // Value fed into the first stage for the given mode
    function automatic logic stage_input(input logic ring, input logic val,
                                         input logic seeded, input logic last);
        if (ring == MODE_RING) begin
            stage_input = ~seeded | last;
        end else begin
            stage_input = val;
        end
    endfunction

    // Two flops on every switch and mode pin before any logic reads it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            syncA_ff <= 4'h0;
            syncB_ff <= 4'h0;
        end else begin
            syncA_ff <= {ringMode, clear_in, value_in, shift_pulse_in};
            syncB_ff <= syncA_ff;
        end
    end

    assign pulseSync = syncB_ff[0];
    assign valueSync = syncB_ff[1];
    assign clearSync = syncB_ff[2];
    assign modeSync = syncB_ff[3];

    // Scan cycle divider, one tick per scan
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scanCnt_ff <= '0;
            scanTick_ff <= 1'h0;
        end else if (scanCnt_ff == SCAN_W'(SCAN_COUNT - 1)) begin
            scanCnt_ff <= '0;
            scanTick_ff <= 1'h1;
        end else begin
            scanCnt_ff <= scanCnt_ff + 1'b1;
            scanTick_ff <= 1'h0;
        end
    end

    assign scanTick = scanTick_ff;

    // Free-running flasher, equal on and off times
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flashCnt_ff <= '0;
            flash_ff <= FLASH_RESET;
        end else if (flashCnt_ff == FLASH_W'(FLASH_COUNT - 1)) begin
            flashCnt_ff <= '0;
            flash_ff <= ~flash_ff;
        end else begin
            flashCnt_ff <= flashCnt_ff + 1'b1;
        end
    end

    assign flasher_timer = flash_ff;

    // Mode taken from the static pin once per scan
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_ff <= MODE_SHIFT;
        end else if (scanTick_ff) begin
            mode_ff <= modeSync;
        end
    end

    // Shift source is the flasher in ring mode
    assign shiftSrc = (mode_ff == MODE_RING) ? flash_ff : pulseSync;

    // Edge detection on the chosen source
    scan_edge_detect u_edge (
        .sys_clk(sys_clk),
        .srst(srst),
        .scanTick(scanTick_ff),
        .level(shiftSrc),
        .risePulse(strobe),
        .fallPulse(fallEdge),
        .levelPrev(lockout)
    );

    assign shift_strobe = strobe;
    assign releasePulse = fallEdge;
    assign pulse_lockout_flag = lockout;

    // Snapshot buffer of the stages after each shift
    stage_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .inValid(doShift),
        .inReady(fifoReady),
        .inData(DATA_WIDTH'(nxt_stage)),
        .outValid(snapValid),
        .outReady(snapReady),
        .outData(snapData)
    );

    // Shift acts on a scan with the strobe, or a deferred one, if buffer has room
    assign shiftIn = stage_input(mode_ff, valueSync, seeded_ff, stage_ff[STAGE_LAST]);
    assign doShift = scanTick_ff & ~clearSync
                   & (strobe | (state_ff == SH_WAIT)) & fifoReady;

    // Shift pattern from values held before the strobe
    always_comb begin
        nxt_stage = {stage_ff[2:0], shiftIn};
    end

    // Deferral of a strobe while the buffer is full
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SH_IDLE: begin
                if (scanTick_ff && strobe && !fifoReady && !clearSync) begin
                    nxt_state = SH_WAIT;
                end
            end
            SH_WAIT: begin
                if (doShift || (scanTick_ff && clearSync)) begin
                    nxt_state = SH_IDLE;
                end
            end
            default: begin
                nxt_state = SH_IDLE;
            end
        endcase
    end

    // Shift control state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= SH_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Storage stages, clear first
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage_ff <= STAGE_RESET;
        end else if (scanTick_ff && clearSync) begin
            stage_ff <= STAGE_RESET;
        end else if (doShift) begin
            stage_ff <= nxt_stage;
        end
    end
    // Stages otherwise keep their value

    // Ring seeding flag, set once the first stage is lit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seeded_ff <= SEEDED_RESET;
        end else if (scanTick_ff) begin
            if (clearSync || mode_ff != MODE_RING) begin
                seeded_ff <= SEEDED_RESET;
            end else if (stage_ff[STAGE_FIRST]) begin
                seeded_ff <= 1'h1;
            end
        end
    end

    assign ring_seeded_flag = seeded_ff;

    // Stage and lamp outputs
    assign stage_first = stage_ff[0];
    assign stage_second = stage_ff[1];
    assign stage_third = stage_ff[2];
    assign stage_fourth = stage_ff[3];
    assign lamp_out_first = stage_ff[STAGE_FIRST] & mode_ff;
    assign lamp_out_last = stage_ff[STAGE_LAST] & mode_ff;

endmodule
`default_nettype wire

// ===== core/edge_shift_pkg.sv
// Constants shared by the edge-pulse shift register and its helpers
package edge_shift_pkg;

    // Clock and timing figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCAN_TIME_US = 1000;
    localparam int FLASH_TIME_MS = 500;
    localparam int SCAN_CYCLES = (SCAN_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int FLASH_CYCLES = (FLASH_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // Storage layout
    localparam int STAGE_COUNT = 4;
    localparam int STAGE_FIRST = 0;
    localparam int STAGE_LAST = 3;
    localparam int FIFO_DEPTH = 16;

    // Values after reset
    localparam logic [3:0] STAGE_RESET = 4'h0;
    localparam logic SEEDED_RESET = 1'h0;
    localparam logic FLASH_RESET = 1'h0;

    // Mode select encoding
    localparam logic MODE_SHIFT = 1'h0;
    localparam logic MODE_RING = 1'h1;

    // Shift control states
    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_WAIT = 2'b10
    } shift_state_e;

endpackage

// ===== core/scan_edge_detect.sv
// Rising and falling edge pulses sampled once per scan cycle
`timescale 1ns/10ps
`default_nettype none
module scan_edge_detect
    import edge_shift_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Scan timing
    input wire logic scanTick,
    // Monitored level
    input wire logic level,
    // Pulses, one scan cycle long, and the level from the previous scan
    output logic risePulse,
    output logic fallPulse,
    output logic levelPrev
);

    logic prev_ff;
    logic rise_ff;
    logic fall_ff;

    // Copy of the level from the previous scan
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_ff <= 1'h0;
        end else if (scanTick) begin
            prev_ff <= level;
        end
    end

    // Pulses judged against the previous copy only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rise_ff <= 1'h0;
            fall_ff <= 1'h0;
        end else if (scanTick) begin
            rise_ff <= level & ~prev_ff;
            fall_ff <= ~level & prev_ff;
        end
    end

    assign risePulse = rise_ff;
    assign fallPulse = fall_ff;
    assign levelPrev = prev_ff;

endmodule
`default_nettype wire

// ===== core/stage_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module stage_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic doPush;
    logic doPop;

    // Handshake terms
    assign inReady = (count_ff != (AW + 1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign doPush = inValid & inReady;
    assign doPop = outValid & outReady;
    assign outData = mem_ff[rdPtr_ff];

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doPush) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doPop) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
            end
            if (doPush && !doPop) begin
                count_ff <= count_ff + 1'b1;
            end else if (doPop && !doPush) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== sim/edge_pulse_shift_register4_checker.sv
// Port checks for the edge-pulse shift register
`timescale 1ns/10ps
`default_nettype none
module edge_pulse_shift_register4_checker #(
    parameter int DATA_WIDTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Stages
    input wire logic stage_first,
    input wire logic stage_second,
    input wire logic stage_third,
    input wire logic stage_fourth,
    // Pulses and flags
    input wire logic shift_strobe,
    input wire logic releasePulse,
    input wire logic pulse_lockout_flag,
    input wire logic ring_seeded_flag,
    input wire logic scanTick,
    // Snapshot stream
    input wire logic snapValid,
    input wire logic snapReady,
    input wire logic [DATA_WIDTH-1:0] snapData
);
    wire logic [3:0] st = {stage_fourth, stage_third, stage_second, stage_first};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // Scan timing and pulse shapes
    property p_tick; scanTick |=> !scanTick [*3] ##1 scanTick; endproperty
    a_tick: assert property (p_tick) else $error("scan tick spacing");
    property p_rise; $rose(shift_strobe) |-> shift_strobe [*4] ##1 !shift_strobe; endproperty
    a_rise: assert property (p_rise) else $error("strobe length");
    property p_fall; $rose(releasePulse) |-> releasePulse [*4] ##1 !releasePulse; endproperty
    a_fall: assert property (p_fall) else $error("release length");
    property p_excl; !(shift_strobe && releasePulse); endproperty
    a_excl: assert property (p_excl) else $error("both pulses high");
    property p_lock; $rose(shift_strobe) |-> $past(scanTick) && pulse_lockout_flag; endproperty
    a_lock: assert property (p_lock) else $error("strobe off scan");
    property p_again; pulse_lockout_flag && $past(pulse_lockout_flag) |-> !$rose(shift_strobe);
    endproperty
    a_again: assert property (p_again) else $error("strobe under lockout");
    // Stage movement
    property p_shift; $changed(st) && st != 4'h0 |-> st[3:1] == $past(st[2:0]); endproperty
    a_shift: assert property (p_shift) else $error("stage order");
    property p_hold; $changed(st) && st != 4'h0 |-> snapValid; endproperty
    a_hold: assert property (p_hold) else $error("stage moved without shift");
    property p_rst; $fell(srst) |-> st == 4'h0 && !shift_strobe && !ring_seeded_flag;
    endproperty
    a_rst: assert property (p_rst) else $error("state after reset");
    property p_ring; ring_seeded_flag |-> $onehot0(st); endproperty
    a_ring: assert property (p_ring) else $error("ring not one-hot");
    property p_seed; $rose(ring_seeded_flag) |-> stage_first; endproperty
    a_seed: assert property (p_seed) else $error("seeded early");
    property p_snap; snapValid && !snapReady |=> snapValid && $stable(snapData); endproperty
    a_snap: assert property (p_snap) else $error("snapshot dropped");
    // Main scenarios reached
    c_strobe: cover property ($rose(shift_strobe));
    c_stall: cover property (snapValid && !snapReady);
    c_seed: cover property ($rose(ring_seeded_flag));
endmodule
bind edge_pulse_shift_register4 edge_pulse_shift_register4_checker #(
    .DATA_WIDTH(DATA_WIDTH)) chk (.*);
`default_nettype wire

// ===== sim/relay_panel.sv
// Switch panel and relay sink facing the block
`timescale 1ns/10ps
`default_nettype none
module relay_panel #(
    parameter int SCAN = 4
) (
    // Clock
    input wire logic sys_clk,
    // Switch pins
    output logic shift_pulse_in,
    output logic value_in,
    output logic clear_in,
    output logic ringMode,
    // Relay sink
    output logic snapReady
);
    // Idle pins, value low marks a bad part
    initial begin
        {shift_pulse_in, value_in, clear_in, ringMode, snapReady} = 5'h01;
    end

    // Hold a pin pattern {source, value, clear} for some scans
    task automatic hold(input logic [2:0] pins, input int scans);
        @(posedge sys_clk);
        {shift_pulse_in, value_in, clear_in} <= pins;
        repeat (scans * SCAN) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== sim/test_edge_pulse_shift_register4.sv
// Self-checking bench for the edge-pulse shift register
`timescale 1ns/10ps
`default_nettype none
module test_edge_pulse_shift_register4;
    import edge_shift_pkg::*;
    logic sys_clk = 1'h0;
    logic srst = 1'h1;
    logic shift_pulse_in, value_in, clear_in, ringMode, snapReady;
    logic stage_first, stage_second, stage_third, stage_fourth;
    logic lamp_out_first, lamp_out_last, shift_strobe, releasePulse;
    logic pulse_lockout_flag, ring_seeded_flag, flasher_timer, scanTick;
    logic snapValid;
    logic [3:0] snapData, expStage, v4;
    logic [3:0] expQ[$];
    int err_total, checks_done;
    wire logic [3:0] st = {stage_fourth, stage_third, stage_second, stage_first};

    // Device and switch panel
    edge_pulse_shift_register4 #(.SCAN_COUNT(4), .FLASH_COUNT(20)) uut (.*);
    relay_panel panel (.*);

    // 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endt(input string n);
        $display("test %s done", n);
    endtask

    // One button press, expected snapshot noted
    task automatic press(input logic v, input int hi);
        expStage = {expStage[2:0], v};
        expQ.push_back(expStage);
        panel.hold({1'h1, v, 1'h0}, hi);
        panel.hold({1'h0, v, 1'h0}, 3);
    endtask

    // Wait until every note is popped
    task automatic drain();
        for (int k = 0; k < 3000 && expQ.size() > 0; k++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        check(4'(expQ.size()), 4'h0);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Popped snapshots against the oldest note
    always @(posedge sys_clk) begin
        if (snapValid === 1'h1 && snapReady === 1'h1) begin
            check(snapData, expQ.size() > 0 ? expQ.pop_front() : 4'hX);
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h02193D50));
        expStage = 4'h0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'h0;
        // Table pattern, then random values, long and short presses
        for (int i = 0; i < 9; i++) begin
            press(i < 5 ? 1'(5'h09 >> i) : 1'($urandom), 3 + (i % 2) * 5);
        end
        drain();
        check(st, expStage);
        check({2'h0, pulse_lockout_flag, shift_strobe}, 4'h0);
        endt("shift");
        // Clear alone, then clear during a press
        panel.hold(3'h1, 3);
        expStage = 4'h0;
        check(st, expStage);
        panel.hold(3'h7, 3);
        panel.hold(3'h3, 3);
        panel.hold(3'h2, 2);
        check(st, expStage);
        endt("clear");
        // Stalled sink: one shift past the buffer depth
        panel.snapReady <= 1'h0;
        for (int i = 0; i < 16; i++) press(1'($urandom), 3);
        v4 = expStage;
        press(1'h1, 3);
        check(st, v4);
        check({3'h0, snapValid}, 4'h1);
        panel.snapReady <= 1'h1;
        drain();
        check(st, expStage);
        check({3'h0, snapValid}, 4'h0);
        endt("buffer");
        // Running light from the flasher
        panel.hold(3'h1, 3);
        panel.hold(3'h0, 1);
        panel.ringMode <= 1'h1;
        for (int i = 0; i < 5; i++) expQ.push_back(4'h1 << (i % 4));
        drain();
        check({3'h0, lamp_out_first}, 4'h1);
        check({2'h0, lamp_out_last, ring_seeded_flag}, 4'h1);
        panel.ringMode <= 1'h0;
        panel.hold(3'h0, 4);
        endt("ring");
        complete_run();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
